/* File: logic/ldc_consts.svh */
/*
  Constants of the lamp dimming control block: register offsets, field
  positions, reset values and timing counts.
  Assumes a 50 MHz system clock; included by its bare name.
*/
`ifndef LDC_CONSTS_SVH
`define LDC_CONSTS_SVH

// register offsets, byte addresses on the plain register port
`define LDC_OFF_CTRL        8'h00
`define LDC_OFF_BRIGHT      8'h04
`define LDC_OFF_STATUS      8'h08

// field positions
`define LDC_CTRL_SHDN_BIT   0
`define LDC_ST_LAMP_BIT     5
`define LDC_ST_OC_BIT       6
`define LDC_ST_SHDN_BIT     7
`define LDC_ST_LOCK_BIT     8
`define LDC_ST_UVLO_BIT     9

// reset values
`define LDC_CTRL_RST        1'h0
`define LDC_BRIGHT_RST      5'h00

// clock and pwm timing
`define LDC_CLK_HZ          50000000
`define LDC_DIGITAL_DIMMING_PWM_HZ         210
`define LDC_DIGITAL_DIMMING_PWM_TICKS      128
`define LDC_TICK_CYC        (`LDC_CLK_HZ / (`LDC_DIGITAL_DIMMING_PWM_HZ * `LDC_DIGITAL_DIMMING_PWM_TICKS))
`define LDC_SYNC_MIN_HZ     32000
`define LDC_SYNC_LOSS_CYC   (2 * `LDC_CLK_HZ / `LDC_SYNC_MIN_HZ)
`define LDC_LAMP_OUT_MS     1000
`define LDC_LAMP_OUT_CYC    (`LDC_CLK_HZ / 1000 * `LDC_LAMP_OUT_MS)

// duty mapping: 9 % floor, 3.125 % (4 of 128 ticks) per code step
`define LDC_MIN_DUTY_PCT    9
`define LDC_MIN_DUTY_TICKS  ((`LDC_MIN_DUTY_PCT * `LDC_DIGITAL_DIMMING_PWM_TICKS + 99) / 100)
`define LDC_STEP_TICKS      4
`define LDC_CLAMP_CODE      4
`define LDC_CODE_MAX        31
`define LDC_ADC_DIV         33

`endif

/* File: logic/ldc_pkg.sv */
/*
  Types of the lamp dimming control block.
  Assumes ldc_consts.svh holds all numeric constants.
*/
`default_nettype none

package ldc_pkg;

  // how the minimum-level reference pin sets the dimming method
  typedef enum logic [1:0] {
    LDC_DIM_CURRENT_ONLY,
    LDC_DIM_PWM_ONLY,
    LDC_DIM_COMBINED
  } ldc_dim_e;

  // interface selected by the mode pin level
  typedef enum logic [1:0] {
    LDC_IF_DIGITAL,
    LDC_IF_NEG_SCALE,
    LDC_IF_POS_SCALE
  } ldc_if_e;

  // asynchronous pin and comparator levels, synchronised as one group
  typedef struct packed {
    logic mode_vcc;
    logic mode_ref;
    logic mode_sync;
    logic minimum_level_reference_vcc;
    logic minimum_level_reference_ref;
    logic shdn;
    logic uvlo;
    logic ifb_low;
    logic oc;
    logic sw_start;
  } ldc_pins_s;

endpackage : ldc_pkg

`default_nettype wire

/* File: logic/ldc_sync.sv */
/*
  Two-flop level synchroniser, one chain per bit.
  Assumes inputs may change at any time relative to the clock.
*/
`default_nettype none

module ldc_sync #(
  parameter int W = 1
) (
  input  wire logic         I_CLOCK,
  input  wire logic         I_SYS_RST,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  // the first flop feeds only the second
  genvar b;
  generate
    for (b = 0; b < W; b++) begin : g_bit
      logic meta_reg;
      logic sync_reg;
      always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
          meta_reg <= 1'h0;
          sync_reg <= 1'h0;
        end else begin
          meta_reg <= i_async[b];
          sync_reg <= meta_reg;
        end
      end
      assign o_sync[b] = sync_reg;
    end
  endgenerate

endmodule // ldc_sync

`default_nettype wire

/* File: logic/ldc_lamp_ctrl.sv */
/*
  Lamp dimming and protection control: method selection, hysteretic
  brightness converter, digital dimming pwm with optional sync lock,
  shutdown, undervoltage lockout, lamp-out and overcurrent handling.
  Assumes the analog inputs arrive as samples from an adc on I_CLOCK,
  all other levels come from pins or comparators asynchronously, and
  I_SYS_RST is the power-on reset.
*/
// Chosen here: the address-and-strobe port and the placing of the registers.
`default_nettype none
`include "ldc_consts.svh"

module ldc_lamp_ctrl #(
  parameter int LAMP_OUT_CYC = `LDC_LAMP_OUT_CYC
) (
  input  wire logic        I_CLOCK,
  input  wire logic        I_SYS_RST,
  // register port
  input  wire logic [7:0]  I_REG_ADDR,
  input  wire logic [31:0] I_REG_WDATA,
  input  wire logic        I_REG_WR,
  input  wire logic        I_REG_RD,
  output logic      [31:0] O_REG_RDATA,
  // analog samples, same clock
  input  wire logic [11:0] I_CTL_LEVEL,
  input  wire logic [11:0] I_CRF_LEVEL,
  // asynchronous pin and comparator levels
  input  wire logic        I_MODE_AT_VCC,
  input  wire logic        I_MODE_AT_REF,
  input  wire logic        I_MODE_SYNC,
  input  wire logic        I_MINLVL_AT_VCC,
  input  wire logic        I_MINLVL_AT_REF,
  input  wire logic        I_SHDN_PIN,
  input  wire logic        I_UVLO_LOW,
  input  wire logic        I_IFB_LOW,
  input  wire logic        I_SW_OVERCURRENT,
  input  wire logic        I_SW_CYCLE_START,
  // outputs to the power stage and current loop
  output logic             O_DIGITAL_DIMMING_PWM_ON,
  output logic      [4:0]  O_CURRENT_CODE,
  output logic             O_HS_EN,
  output logic             O_LS_EN,
  output logic             O_LAMP_FAULT,
  output logic             O_OC_FAULT,
  output logic             O_SHUTDOWN
);

  localparam int TICK_CYC  = `LDC_TICK_CYC;
  localparam int LOSS_CYC  = `LDC_SYNC_LOSS_CYC;
  localparam int MIN_TICKS = `LDC_MIN_DUTY_TICKS;

  // pin synchronisation
  ldc_pkg::ldc_pins_s pins_async;
  ldc_pkg::ldc_pins_s pins;
  logic [9:0]         pins_vec;

  assign pins_async = '{
    mode_vcc:   I_MODE_AT_VCC,
    mode_ref:   I_MODE_AT_REF,
    mode_sync:  I_MODE_SYNC,
    minimum_level_reference_vcc: I_MINLVL_AT_VCC,
    minimum_level_reference_ref: I_MINLVL_AT_REF,
    shdn:       I_SHDN_PIN,
    uvlo:       I_UVLO_LOW,
    ifb_low:    I_IFB_LOW,
    oc:         I_SW_OVERCURRENT,
    sw_start:   I_SW_CYCLE_START
  };

  ldc_sync #(.W(10)) u_sync (
    .I_CLOCK   (I_CLOCK),
    .I_SYS_RST (I_SYS_RST),
    .i_async   (pins_async),
    .o_sync    (pins_vec)
  );
  assign pins = ldc_pkg::ldc_pins_s'(pins_vec);

  // state
  logic        shdn_ctl_reg;
  logic [4:0]  bright_reg;
  logic [4:0]  adc_code_reg;
  logic [4:0]  code_reg;
  logic [6:0]  tick_cnt_reg;
  logic [10:0] osc_cnt_reg;
  logic [11:0] sync_age_reg;
  logic        sync_d_reg;
  logic        swst_d_reg;
  logic [25:0] lamp_cnt_reg;
  logic        lamp_fault_reg;
  logic        oc_fault_reg;
  logic        oc_cut_reg;
  logic        digital_dimming_pwm_on_reg;
  logic [4:0]  cur_code_reg;
  logic        hs_en_reg;
  logic        ls_en_reg;
  logic [31:0] rdata_reg;
  logic        sync_locked;

  // interface and dimming method decode
  ldc_pkg::ldc_if_e  if_mode;
  ldc_pkg::ldc_dim_e dim_mode;

  assign if_mode = pins.mode_vcc ? ldc_pkg::LDC_IF_DIGITAL :
                   pins.mode_ref ? ldc_pkg::LDC_IF_NEG_SCALE :
                                   ldc_pkg::LDC_IF_POS_SCALE;
  assign dim_mode = pins.minimum_level_reference_vcc ? ldc_pkg::LDC_DIM_CURRENT_ONLY :
                    pins.minimum_level_reference_ref ? ldc_pkg::LDC_DIM_PWM_ONLY :
                                      ldc_pkg::LDC_DIM_COMBINED;

  // shutdown: register bit only counts in digital mode
  wire logic digital   = (if_mode == ldc_pkg::LDC_IF_DIGITAL);
  wire logic shutdown  = pins.shdn | (digital & shdn_ctl_reg);
  wire logic running   = ~shutdown & ~lamp_fault_reg;

  // register port decode
  wire logic sel_ctrl   = (I_REG_ADDR == `LDC_OFF_CTRL);
  wire logic sel_bright = (I_REG_ADDR == `LDC_OFF_BRIGHT);
  wire logic sel_status = (I_REG_ADDR == `LDC_OFF_STATUS);

  // register writes stay live in shutdown
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      shdn_ctl_reg <= `LDC_CTRL_RST;
      bright_reg   <= `LDC_BRIGHT_RST;
    end else if (I_REG_WR) begin
      if (sel_ctrl) begin
        shdn_ctl_reg <= I_REG_WDATA[`LDC_CTRL_SHDN_BIT];
      end
      if (sel_bright) begin
        bright_reg <= I_REG_WDATA[4:0];
      end
    end
  end

  // read data, one cycle after the strobe, zero elsewhere
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[4:0] = code_reg;
    status_word[`LDC_ST_LAMP_BIT] = lamp_fault_reg;
    status_word[`LDC_ST_OC_BIT]   = oc_fault_reg;
    status_word[`LDC_ST_SHDN_BIT] = shutdown;
    status_word[`LDC_ST_LOCK_BIT] = sync_locked;
    status_word[`LDC_ST_UVLO_BIT] = pins.uvlo;
  end

  wire logic [31:0] rdata_next =
      ~I_REG_RD  ? 32'h0000_0000 :
      sel_ctrl   ? {31'h0000_0000, shdn_ctl_reg} :
      sel_bright ? {27'h000_0000, bright_reg} :
      sel_status ? status_word : 32'h0000_0000;

  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // hysteretic converter: compare ctl*33 with k*crf
  wire logic [17:0] ctl33 = 18'(I_CTL_LEVEL) * 18'(`LDC_ADC_DIV);
  wire logic [17:0] crf   = 18'(I_CRF_LEVEL);
  wire logic [17:0] n     = 18'(adc_code_reg);
  wire logic [17:0] thr_pos_up = (n + 18'h00002) * crf;
  wire logic [17:0] thr_pos_dn = n * crf;
  wire logic [17:0] thr_neg_up = (18'(`LDC_ADC_DIV) - n) * crf;
  wire logic [17:0] thr_neg_dn = (18'(`LDC_CODE_MAX) - n) * crf;
  wire logic at_top = (adc_code_reg == 5'h1F);
  wire logic at_bot = (adc_code_reg == 5'h00);

  // gap between thresholds is the one-step hysteresis
  logic adc_inc;
  logic adc_dec;
  always_comb begin
    adc_inc = 1'h0;
    adc_dec = 1'h0;
    if (if_mode == ldc_pkg::LDC_IF_POS_SCALE) begin
      adc_inc = ~at_top & (ctl33 > thr_pos_up);
      adc_dec = ~at_bot & (ctl33 < thr_pos_dn);
    end else if (if_mode == ldc_pkg::LDC_IF_NEG_SCALE) begin
      adc_dec = ~at_bot & (ctl33 > thr_neg_up);
      adc_inc = ~at_top & (ctl33 < thr_neg_dn);
    end
  end

  // one step per clock; a jump of n codes settles in n cycles, up to 31
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      adc_code_reg <= 5'h00;
    end else if (adc_inc) begin
      adc_code_reg <= adc_code_reg + 5'h01;
    end else if (adc_dec) begin
      adc_code_reg <= adc_code_reg - 5'h01;
    end
  end

  wire logic [4:0] sel_code = digital ? bright_reg : adc_code_reg;

  // sync detection on the mode pin
  wire logic sync_rise   = pins.mode_sync & ~sync_d_reg;
  assign sync_locked = (sync_age_reg < 12'(LOSS_CYC));

  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      sync_d_reg   <= 1'h0;
      sync_age_reg <= 12'(LOSS_CYC);
    end else begin
      sync_d_reg <= pins.mode_sync;
      if (sync_rise) begin
        sync_age_reg <= 12'h000;
      end else if (sync_locked) begin
        sync_age_reg <= sync_age_reg + 12'h001;
      end
    end
  end

  // internal oscillator tick when no sync is present
  wire logic osc_tick = (osc_cnt_reg == 11'(TICK_CYC - 1));
  wire logic tick     = sync_locked ? sync_rise : osc_tick;

  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST || osc_tick) begin
      osc_cnt_reg <= 11'h000;
    end else begin
      osc_cnt_reg <= osc_cnt_reg + 11'h001;
    end
  end

  // 128 ticks per period; while running, code latched only at the boundary
  wire logic boundary = tick & (tick_cnt_reg == 7'h7F);

  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST || !running) begin
      tick_cnt_reg <= 7'h00;
      code_reg     <= sel_code;  // idle: follow directly
    end else if (tick) begin
      tick_cnt_reg <= tick_cnt_reg + 7'h01;
      if (boundary) begin
        code_reg <= sel_code;
      end
    end
  end

  // duty in ticks: floor for low codes, 4 ticks per step above
  wire logic [7:0] step_ticks = (8'(code_reg) + 8'h01) * 8'(`LDC_STEP_TICKS);
  wire logic [7:0] on_ticks   = (code_reg < 5'(`LDC_CLAMP_CODE)) ?
                                8'(MIN_TICKS) : step_ticks;
  // code 31 gives 128 ticks, on for the whole period
  wire logic pwm_phase = ({1'h0, tick_cnt_reg} < on_ticks);

  logic       digital_dimming_pwm_next;
  logic [4:0] cur_code_next;
  always_comb begin
    case (dim_mode)
      ldc_pkg::LDC_DIM_CURRENT_ONLY: begin
        digital_dimming_pwm_next     = 1'h1;
        cur_code_next = code_reg;
      end
      ldc_pkg::LDC_DIM_PWM_ONLY: begin
        digital_dimming_pwm_next     = pwm_phase;
        cur_code_next = 5'h1F;
      end
      ldc_pkg::LDC_DIM_COMBINED: begin
        digital_dimming_pwm_next     = pwm_phase;
        cur_code_next = code_reg;
      end
      default: begin
        digital_dimming_pwm_next     = 1'h0;
        cur_code_next = 5'h00;
      end
    endcase
  end

  // lamp-out timer counts on-phase time with low feedback peaks
  wire logic lamp_low   = running & digital_dimming_pwm_on_reg & pins.ifb_low;
  wire logic lamp_limit = (lamp_cnt_reg == 26'(LAMP_OUT_CYC - 1));

  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST || shutdown) begin
      lamp_cnt_reg <= 26'h000_0000;
    end else if (!pins.ifb_low) begin
      lamp_cnt_reg <= 26'h000_0000;  // peak recovered, restart
    end else if (lamp_low && !lamp_limit) begin
      lamp_cnt_reg <= lamp_cnt_reg + 26'h000_0001;
    end
  end

  // faults: latched, cleared by power-on reset or shutdown
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      lamp_fault_reg <= 1'h0;
      oc_fault_reg   <= 1'h0;
    end else if (shutdown) begin
      lamp_fault_reg <= 1'h0;
      oc_fault_reg   <= 1'h0;
    end else begin
      if (lamp_low && lamp_limit) begin
        lamp_fault_reg <= 1'h1;
      end
      if (pins.oc) begin
        oc_fault_reg <= 1'h1;
      end
    end
  end

  // high-side cut holds until the next switching cycle; set wins
  wire logic sw_rise    = pins.sw_start & ~swst_d_reg;
  wire logic oc_cut_next = pins.oc | (oc_cut_reg & ~sw_rise);

  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      swst_d_reg <= 1'h0;
      oc_cut_reg <= 1'h0;
    end else begin
      swst_d_reg <= pins.sw_start;
      oc_cut_reg <= oc_cut_next & running;
    end
  end

  // driver enables; undervoltage blocks both sides
  wire logic drive = running & digital_dimming_pwm_next & ~pins.uvlo;

  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      digital_dimming_pwm_on_reg  <= 1'h0;
      cur_code_reg <= 5'h00;
      hs_en_reg    <= 1'h0;
      ls_en_reg    <= 1'h0;
    end else begin
      digital_dimming_pwm_on_reg  <= running & digital_dimming_pwm_next;
      cur_code_reg <= running ? cur_code_next : 5'h00;
      hs_en_reg    <= drive & ~oc_cut_next;
      ls_en_reg    <= drive;
    end
  end

  assign O_REG_RDATA    = rdata_reg;
  assign O_DIGITAL_DIMMING_PWM_ON      = digital_dimming_pwm_on_reg;
  assign O_CURRENT_CODE = cur_code_reg;
  assign O_HS_EN        = hs_en_reg;
  assign O_LS_EN        = ls_en_reg;
  assign O_LAMP_FAULT   = lamp_fault_reg;
  assign O_OC_FAULT     = oc_fault_reg;
  assign O_SHUTDOWN     = shutdown;

endmodule // ldc_lamp_ctrl

`default_nettype wire

/* File: test/ldc_lamp_ctrl_assertions.sv */
/*
  Port checks of the lamp dimming control block.
  Assumes one clock domain and the bind at the foot of this file.
*/
`default_nettype none
`include "ldc_consts.svh"

module ldc_lamp_ctrl_checker #(
  parameter int LAMP_OUT_CYC = 200
) (
  input wire logic        I_CLOCK,
  input wire logic        I_SYS_RST,
  input wire logic [7:0]  I_REG_ADDR,
  input wire logic [31:0] I_REG_WDATA,
  input wire logic        I_REG_WR,
  input wire logic        I_MODE_AT_VCC,
  input wire logic        I_MINLVL_AT_VCC,
  input wire logic        I_SHDN_PIN,
  input wire logic        I_UVLO_LOW,
  input wire logic        I_IFB_LOW,
  input wire logic        I_SW_OVERCURRENT,
  input wire logic        O_DIGITAL_DIMMING_PWM_ON,
  input wire logic        O_HS_EN,
  input wire logic        O_LS_EN,
  input wire logic        O_LAMP_FAULT,
  input wire logic        O_OC_FAULT,
  input wire logic        O_SHUTDOWN
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_SYS_RST);

  // feedback missing; the count pauses in the off-phase, as the timer does
  wire lamp_miss = I_IFB_LOW && !O_SHUTDOWN && !O_LAMP_FAULT;
  int  lamp_cnt_reg;
  int  lamp_cnt_next;
  assign lamp_cnt_next = !lamp_miss ? 0 : (O_DIGITAL_DIMMING_PWM_ON ? lamp_cnt_reg + 1 : lamp_cnt_reg);

  // raw pin counts lead the design by the synchroniser depth
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) lamp_cnt_reg <= 0;
    else lamp_cnt_reg <= lamp_cnt_next;
  end

  property p_rst_clear;
    $fell(I_SYS_RST) |-> !O_HS_EN && !O_LS_EN && !O_LAMP_FAULT && !O_OC_FAULT && !O_DIGITAL_DIMMING_PWM_ON;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("outputs not clear after reset");
  property p_uvlo;
    I_UVLO_LOW [*5] |-> !O_HS_EN && !O_LS_EN;
  endproperty
  a_uvlo: assert property (p_uvlo) else $error("drivers on below supply limit");
  property p_shdn_stop;
    O_SHUTDOWN [*3] |-> !O_HS_EN && !O_LS_EN && !O_DIGITAL_DIMMING_PWM_ON;
  endproperty
  a_shdn_stop: assert property (p_shdn_stop) else $error("activity in shutdown");
  property p_shdn_clr;
    $rose(O_SHUTDOWN) |-> ##[0:2] (!O_LAMP_FAULT && !O_OC_FAULT);
  endproperty
  a_shdn_clr: assert property (p_shdn_clr) else $error("faults kept in shutdown");
  property p_pin_shdn;
    I_SHDN_PIN [*4] |-> O_SHUTDOWN;
  endproperty
  a_pin_shdn: assert property (p_pin_shdn) else $error("pin shutdown ignored");
  property p_reg_shdn;
    (I_MODE_AT_VCC [*4] ##0 (I_REG_WR && I_REG_ADDR == `LDC_OFF_CTRL && I_REG_WDATA[0]))
      |=> ##[0:1] O_SHUTDOWN;
  endproperty
  a_reg_shdn: assert property (p_reg_shdn) else $error("register shutdown ignored");
  property p_lamp_early;
    $rose(O_LAMP_FAULT) |-> lamp_cnt_reg >= LAMP_OUT_CYC;
  endproperty
  a_lamp_early: assert property (p_lamp_early) else $error("lamp fault too early");
  property p_lamp_late;
    lamp_cnt_reg <= LAMP_OUT_CYC + 8;
  endproperty
  a_lamp_late: assert property (p_lamp_late) else $error("lamp fault missing");
  property p_lamp_off;
    O_LAMP_FAULT |=> !O_HS_EN && !O_LS_EN;
  endproperty
  a_lamp_off: assert property (p_lamp_off) else $error("bridge on after lamp fault");
  property p_oc_cut;
    I_SW_OVERCURRENT [*5] |-> !O_HS_EN;
  endproperty
  a_oc_cut: assert property (p_oc_cut) else $error("high side on over limit");
  property p_full_duty;
    (I_MINLVL_AT_VCC [*8] ##0 (!O_SHUTDOWN && !O_LAMP_FAULT) [*2]) |-> O_DIGITAL_DIMMING_PWM_ON;
  endproperty
  a_full_duty: assert property (p_full_duty) else $error("dimming pwm off in current mode");

  c_lamp: cover property ($rose(O_LAMP_FAULT));
  c_oc: cover property (I_SW_OVERCURRENT ##1 !O_HS_EN);
  c_shdn: cover property ($rose(O_SHUTDOWN));
endmodule // ldc_lamp_ctrl_checker

bind ldc_lamp_ctrl ldc_lamp_ctrl_checker #(
  .LAMP_OUT_CYC(LAMP_OUT_CYC)
) u_ldc_lamp_ctrl_checker (
  .I_CLOCK, .I_SYS_RST, .I_REG_ADDR, .I_REG_WDATA, .I_REG_WR, .I_MODE_AT_VCC,
  .I_MINLVL_AT_VCC, .I_SHDN_PIN, .I_UVLO_LOW, .I_IFB_LOW, .I_SW_OVERCURRENT, .O_DIGITAL_DIMMING_PWM_ON,
  .O_HS_EN, .O_LS_EN, .O_LAMP_FAULT, .O_OC_FAULT, .O_SHUTDOWN
);

`default_nettype wire

/* File: test/ldc_stage_model.sv */
/*
  Far-side model: sync source on the mode pin and the bridge power stage.
  Assumes the bench commands lamp opening and overcurrent.
*/
`default_nettype none

module ldc_stage_model (
  input  wire logic i_clk,
  input  wire logic i_lamp_open,
  input  wire logic i_oc_cmd,
  output logic      o_sync,
  output logic      o_sw_start,
  output logic      o_ifb_low,
  output logic      o_oc
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] ph_reg = 4'h0;

  // free-running phase; sync faster than a real source keeps periods short
  always @(posedge i_clk) ph_reg <= ph_reg + 4'h1;

  assign o_sync     = ph_reg[3]; // one rising edge every 16 cycles
  assign o_sw_start = ph_reg[2]; // new switching cycle every 8 cycles
  assign o_ifb_low  = i_lamp_open;
  assign o_oc       = i_oc_cmd;
endmodule // ldc_stage_model

`default_nettype wire

/* File: test/testbench.sv */
/*
  Self-checking bench of the lamp dimming control block.
  Assumes the stage model drives sync, switching and fault levels.
*/
`default_nettype none
`include "ldc_consts.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LAMP_CYC = 200;
  localparam int TICK     = 16;
  localparam int PERIOD   = 128 * TICK;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [11:0] ctl = 12'h000;
  logic [11:0] crf = 12'h000;
  logic        mode_vcc = 1'b1;
  logic        mode_ref = 1'b0;
  logic        lvl_vcc = 1'b0;
  logic        lvl_ref = 1'b0;
  logic        shdn_pin = 1'b0;
  logic        uvlo = 1'b0;
  logic        lamp_open = 1'b0;
  logic        oc_cmd = 1'b0;
  logic        sync, sw_start, ifb_low, oc, digital_dimming_pwm, hs, ls, lamp_f, oc_f, shdn;
  logic [31:0] rdata;
  logic [4:0]  ccode;
  int          fail_count = 0;
  int          num_checks = 0;

  // 50 MHz clock
  always #10 clk = ~clk;

  ldc_stage_model u_ldc_stage_model (.i_clk(clk), .i_lamp_open(lamp_open), .i_oc_cmd(oc_cmd),
    .o_sync(sync), .o_sw_start(sw_start), .o_ifb_low(ifb_low), .o_oc(oc));

  ldc_lamp_ctrl #(.LAMP_OUT_CYC(LAMP_CYC)) u_ldc_lamp_ctrl (.I_CLOCK(clk), .I_SYS_RST(rst),
    .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata),
    .I_CTL_LEVEL(ctl), .I_CRF_LEVEL(crf), .I_MODE_AT_VCC(mode_vcc), .I_MODE_AT_REF(mode_ref),
    .I_MODE_SYNC(sync), .I_MINLVL_AT_VCC(lvl_vcc), .I_MINLVL_AT_REF(lvl_ref),
    .I_SHDN_PIN(shdn_pin), .I_UVLO_LOW(uvlo), .I_IFB_LOW(ifb_low), .I_SW_OVERCURRENT(oc),
    .I_SW_CYCLE_START(sw_start), .O_DIGITAL_DIMMING_PWM_ON(digital_dimming_pwm), .O_CURRENT_CODE(ccode), .O_HS_EN(hs),
    .O_LS_EN(ls), .O_LAMP_FAULT(lamp_f), .O_OC_FAULT(oc_f), .O_SHUTDOWN(shdn));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic chk_b(input string what, input logic exp, input logic got);
    chk(what, {31'h0, exp}, {31'h0, got});
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_chk(input string what, input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(what, exp, rdata & m);
  endtask

  task automatic wait_chk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic t_dim(input logic [4:0] code, input logic full, input logic pwm_only);
    int n;
    int on;
    n = 0;
    on = full ? 128 : (code < 5'h04 ? 12 : (int'(code) + 1) * 4);
    reg_wr(`LDC_OFF_BRIGHT, {27'h0, code});
    wait_chk(2 * PERIOD + 64);
    chk("current code", {27'h0, pwm_only ? 5'h1F : code}, {27'h0, ccode});
    // a full period from any phase holds exactly one on-phase
    repeat (PERIOD) begin
      @(posedge clk);
      #1;
      if (digital_dimming_pwm === 1'b1) n++;
    end
    chk("on cycles", 32'(on * TICK), 32'(n));
    reg_chk("sync lock", `LDC_OFF_STATUS, 32'h100, 32'h100);
    $display("test dimming code %0d done", code);
  endtask

  task automatic t_faults;
    @(posedge clk);
    oc_cmd <= 1'b1;
    wait_chk(10);
    chk_b("hs under oc", 1'b0, hs);
    chk_b("ls under oc", 1'b1, ls);
    @(posedge clk);
    oc_cmd <= 1'b0;
    wait_chk(30);
    chk_b("hs after oc", 1'b1, hs);
    @(posedge clk);
    lamp_open <= 1'b1;
    wait_chk(LAMP_CYC - 50);
    chk_b("early lamp fault", 1'b0, lamp_f);
    wait_chk(70);
    chk_b("lamp fault", 1'b1, lamp_f);
    chk_b("ls on lamp fault", 1'b0, ls);
    reg_chk("fault bits", `LDC_OFF_STATUS, 32'h60, 32'h60);
    reg_wr(`LDC_OFF_CTRL, 32'h1);
    wait_chk(3);
    chk_b("reg shutdown", 1'b1, shdn);
    chk_b("lamp fault cleared", 1'b0, lamp_f);
    chk_b("oc fault cleared", 1'b0, oc_f);
    reg_wr(`LDC_OFF_BRIGHT, 32'h15);
    reg_chk("bright in shutdown", `LDC_OFF_BRIGHT, 32'h1F, 32'h15);
    @(posedge clk);
    lamp_open <= 1'b0;
    reg_wr(`LDC_OFF_CTRL, 32'h0);
    @(posedge clk);
    uvlo <= 1'b1;
    wait_chk(8);
    chk_b("hs low supply", 1'b0, hs);
    chk_b("ls low supply", 1'b0, ls);
    @(posedge clk);
    uvlo <= 1'b0;
    shdn_pin <= 1'b1;
    wait_chk(6);
    chk_b("pin shutdown", 1'b1, shdn);
    @(posedge clk);
    shdn_pin <= 1'b0;
    wait_chk(6);
    chk_b("pin release", 1'b0, shdn);
    $display("test faults and shutdown done");
  endtask

  task automatic t_adc;
    logic        neg[6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    logic [11:0] lvl[6] = '{12'h60E, 12'h5AA, 12'h546, 12'h60E, 12'h672, 12'h6D6};
    logic [4:0]  exp[6] = '{5'h0E, 5'h0E, 5'h0D, 5'h10, 5'h10, 5'h0F};
    @(posedge clk);
    mode_vcc <= 1'b0;
    crf <= 12'hCE4;
    // mid-gap levels keep clear of threshold rounding
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      mode_ref <= neg[i];
      ctl <= lvl[i];
      wait_chk(PERIOD + 128);
      reg_chk("adc code", `LDC_OFF_STATUS, 32'h1F, {27'h0, exp[i]});
    end
    $display("test analog converter done");
  endtask

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    $display("unexpected run length: expected under 100000 cycles, seen more");
    wrap_up();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk_b("reset lamp fault", 1'b0, lamp_f);
    reg_chk("reset ctrl", `LDC_OFF_CTRL, 32'hFFFFFFFF, 32'h0);
    reg_chk("reset bright", `LDC_OFF_BRIGHT, 32'hFFFFFFFF, 32'h0);
    reg_chk("unmapped", 8'h0C, 32'hFFFFFFFF, 32'h0);
    $display("test reset done");
    t_dim(5'h00, 1'b0, 1'b0);
    t_dim(5'h03, 1'b0, 1'b0);
    t_dim(5'h04, 1'b0, 1'b0);
    t_dim(5'h1E, 1'b0, 1'b0);
    @(posedge clk);
    lvl_ref <= 1'b1;
    t_dim(5'h04, 1'b0, 1'b1);
    @(posedge clk);
    lvl_ref <= 1'b0;
    lvl_vcc <= 1'b1;
    t_dim(5'h04, 1'b1, 1'b0);
    @(posedge clk);
    lvl_vcc <= 1'b0;
    t_dim(5'h1F, 1'b0, 1'b0);
    t_faults();
    t_adc();
    wrap_up();
  end
endmodule // testbench

`default_nettype wire
